// File: tb.sv
`timescale 1ns/1ps
module tb;
  localparam int WIN_T = 20;
  localparam int PER_T = 30;
  localparam int FS = WIN_T * wpr_pkg::TICK_NS * wpr_pkg::FS_RATE_KPPS / 1000000;
  localparam int TCYC = wpr_pkg::TICK_NS / wpr_pkg::CLK_NS;
  localparam logic [31:0] UPD = 32'h1 << wpr_pkg::ST_UPDATE;
  logic mclk, reset_n, psel, penable, pwrite, pready, pslverr, perr, gate, tpulse, irq, lcmp, ucmp;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [8:0] lthr, uthr, rcode;
  int fails, total_checks;

  wpr_ratemeter #(.WINDOW_TICKS(16'(WIN_T)), .PERIOD_TICKS(16'(PER_T))) i_wpr_ratemeter (
    .mclk(mclk), .reset_n(reset_n), .lower_threshold_comparator(lcmp), .upper_threshold_comparator(ucmp),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .lower_threshold_code(lthr), .upper_threshold_code(uthr),
    .rate_code(rcode), .gate_broadcast_line_a(gate), .test_pulse(tpulse), .irq(irq));
  wpr_comp_model i_wpr_comp_model (.mclk(mclk), .lower_threshold_comparator(lcmp),
    .upper_threshold_comparator(ucmp));

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("unexpected %s: expected %0h, seen %0h", nm, exp, got);
    end
  endtask : chk

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge mclk);
    penable <= 1'b1;
    @(posedge mclk);
    while (pready !== 1'b1 && n < 50) begin
      @(posedge mclk);
      n++;
    end
    if (n >= 50) begin
      fails++;
    end
    rd = prdata;
    perr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge mclk);
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr

  task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(nm, exp, rd);
  endtask : rdc

  task automatic irq_is(input logic e);
    @(negedge mclk);
    chk("irq", 32'(e), 32'(irq));
    @(posedge mclk);
  endtask : irq_is

  task automatic wait_upd();
    int n;
    n = 0;
    wr(wpr_pkg::REG_STATUS, UPD);
    rd = 32'h0;
    while ((rd & UPD) !== UPD && n < 3000) begin
      apb(1'b0, wpr_pkg::REG_STATUS, 32'h0);
      n++;
    end
    if (n >= 3000) begin
      fails++;
    end
    wr(wpr_pkg::REG_STATUS, UPD);
  endtask : wait_upd

  task automatic gate_rise();
    int n;
    n = 0;
    while (gate !== 1'b0 && n < 9000) begin
      @(negedge mclk);
      n++;
    end
    while (gate !== 1'b1 && n < 9000) begin
      @(negedge mclk);
      n++;
    end
    if (n >= 9000) begin
      fails++;
    end
  endtask : gate_rise

  // One window with a given pulse mix, then totals and code judged
  task automatic measure(input logic [31:0] ctrl, input int nwin, input int nboth, input int nup, input int w);
    int lo, up, d, code;
    lo = nwin + nboth;
    up = nboth + nup;
    d = (lo > up) ? lo - up : 0;
    code = (d >= FS) ? 511 : d * 511 / FS;
    wait_upd();
    wr(wpr_pkg::REG_CTRL, ctrl);
    gate_rise();
    i_wpr_comp_model.burst(nwin, 1, w);
    i_wpr_comp_model.burst(nboth, 2, w);
    i_wpr_comp_model.burst(nup, 3, w);
    wait_upd();
    rdc("lower total lo", wpr_pkg::REG_LOWER_LO, 32'(lo));
    rdc("lower total hi", wpr_pkg::REG_LOWER_HI, 32'h0);
    rdc("upper total lo", wpr_pkg::REG_UPPER_LO, 32'(up));
    rdc("upper total hi", wpr_pkg::REG_UPPER_HI, 32'h0);
    rdc("rate register", wpr_pkg::REG_RATE, 32'(code));
    chk("rate pin", 32'(code), 32'(rcode));
  endtask : measure

  task automatic t_reset();
    repeat (4) @(posedge mclk);
    @(negedge mclk);
    chk("gate after reset", 32'h1, 32'(gate));
    chk("rate pin after reset", 32'h0, 32'(rcode));
    chk("irq after reset", 32'h0, 32'(irq));
    chk("lower thr pin", 32'h132, 32'(lthr));
    chk("upper thr pin", 32'h198, 32'(uthr));
    @(posedge mclk);
    rdc("ctrl", wpr_pkg::REG_CTRL, 32'h3);
    rdc("status", wpr_pkg::REG_STATUS, 32'h0);
    rdc("rate", wpr_pkg::REG_RATE, 32'h0);
  endtask : t_reset

  task automatic t_unmapped();
    apb(1'b0, 8'h40, 32'h0);
    chk("unmapped err", 32'h1, 32'(perr));
    chk("unmapped data", 32'h0, rd);
  endtask : t_unmapped

  task automatic t_gate();
    int hi, lo;
    hi = 0;
    lo = 0;
    gate_rise();
    while (gate === 1'b1 && hi < 9000) begin
      hi++;
      @(negedge mclk);
    end
    while (gate === 1'b0 && lo < 9000) begin
      lo++;
      @(negedge mclk);
    end
    chk("window cycles", 32'(WIN_T * TCYC), 32'(hi));
    chk("stopped cycles", 32'((PER_T - WIN_T) * TCYC), 32'(lo));
    @(posedge mclk);
  endtask : t_gate

  task automatic t_ovf();
    wr(wpr_pkg::REG_MASK, 32'h1);
    measure(32'h3, 270, 0, 0, 2);
    rdc("ovf status", wpr_pkg::REG_STATUS, 32'h1);
    irq_is(1'b1);
    wr(wpr_pkg::REG_MASK, 32'h4);
    irq_is(1'b0);
    wr(wpr_pkg::REG_MASK, 32'h1);
    irq_is(1'b1);
    wr(wpr_pkg::REG_STATUS, 32'h1);
    irq_is(1'b0);
  endtask : t_ovf

  task automatic t_test_pulse();
    int hi;
    hi = 0;
    wr(wpr_pkg::REG_CTRL, 32'h7);
    repeat (2 * wpr_pkg::TEST_PERIOD_CYC) begin
      @(negedge mclk);
      hi += (tpulse === 1'b1) ? 1 : 0;
    end
    chk("test pulse high cycles", 32'(2 * wpr_pkg::TEST_WIDTH_CYC), 32'(hi));
    @(posedge mclk);
  endtask : t_test_pulse

  task automatic t_upper_ovf();
    measure(32'h3, 0, 270, 0, 2);
    rdc("both ovf status", wpr_pkg::REG_STATUS, 32'h3);
    wr(wpr_pkg::REG_STATUS, 32'h3);
    rdc("status cleared", wpr_pkg::REG_STATUS, 32'h0);
  endtask : t_upper_ovf

  task automatic t_run_off();
    wr(wpr_pkg::REG_CTRL, 32'h2);
    repeat (3500) @(posedge mclk);
    @(negedge mclk);
    chk("gate with run off", 32'h0, 32'(gate));
    @(posedge mclk);
  endtask : t_run_off

  task automatic tally_and_finish();
    $display("checks %0d, mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : tally_and_finish

  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end

  initial begin
    #8000000;
    fails++;
    tally_and_finish();
  end

  initial begin
    fails = 0;
    total_checks = 0;
    reset_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    repeat (3) @(posedge mclk);
    reset_n <= 1'b1;
    t_reset();
    t_unmapped();
    measure(32'h3, 30, 10, 0, 6);
    t_gate();
    t_ovf();
    measure(32'h3, 0, 0, 5, 3);
    t_upper_ovf();
    measure(32'h1, 20, 0, 0, 3);
    wr(wpr_pkg::REG_LOWER_THR, 32'hFFFFFFFF);
    rdc("lower thr", wpr_pkg::REG_LOWER_THR, 32'h1FF);
    chk("lower thr pin", 32'h1FF, 32'(lthr));
    t_test_pulse();
    t_run_off();
    tally_and_finish();
  end
endmodule : tb

// File: wpr_comp_model.sv
`timescale 1ns/1ps
module wpr_comp_model (
  input wire logic mclk, // System clock
  output logic lower_threshold_comparator, // Lower-level output, inverted
  output logic upper_threshold_comparator // Upper-level output, inverted
);
  initial begin
    lower_threshold_comparator = 1'b1;
    upper_threshold_comparator = 1'b1;
  end

  // Kind 1 in window, 2 above both levels, 3 upper only (skew fault); upper asserts a cycle after lower and releases a cycle before it
  task automatic burst(input int n, input int kind, input int width);
    for (int i = 0; i < n; i++) begin
      @(posedge mclk);
      lower_threshold_comparator <= !(kind == 1 || kind == 2);
      @(posedge mclk);
      upper_threshold_comparator <= !(kind >= 2);
      repeat (width) @(posedge mclk);
      upper_threshold_comparator <= 1'b1;
      @(posedge mclk);
      lower_threshold_comparator <= 1'b1;
      repeat (width) @(posedge mclk);
    end
  endtask : burst
endmodule : wpr_comp_model

// File: wpr_gate_gen.sv
`timescale 1ns/1ps
module wpr_gate_gen #(
  parameter logic [wpr_pkg::TICK_W-1:0] WINDOW_TICKS = 16'(wpr_pkg::WINDOW_TICKS_DEF),
  parameter logic [wpr_pkg::TICK_W-1:0] PERIOD_TICKS = 16'(wpr_pkg::PERIOD_TICKS_DEF)
) (
  input wire logic mclk, // System clock
  input wire logic reset_n, // Synchronous reset
  input wire logic run, // Gate generator running
  output logic gate_q, // Counting window open
  output logic stop_evt_q // Start of stopped interval
);
  logic [wpr_pkg::PRE_W-1:0] pre_q;
  logic [wpr_pkg::PRE_W-1:0] pre_d;
  logic [wpr_pkg::TICK_W-1:0] tick_q;
  logic [wpr_pkg::TICK_W-1:0] tick_d;
  logic tick;
  logic gate_d;

  assign tick = (pre_q == wpr_pkg::PRE_W'(wpr_pkg::PRESCALE_CYC - 1));
  assign pre_d = (!run || tick) ? '0 : pre_q + 1'b1;
  assign tick_d = !run ? '0 : (!tick ? tick_q : ((tick_q == PERIOD_TICKS - 1'b1) ? '0 : tick_q + 1'b1));
  assign gate_d = run & (tick_d < WINDOW_TICKS);

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      pre_q <= '0;
      tick_q <= '0;
      gate_q <= 1'b0;
      stop_evt_q <= 1'b0;
    end else begin
      pre_q <= pre_d;
      tick_q <= tick_d;
      gate_q <= gate_d;
      // event at start of stopped interval
      stop_evt_q <= gate_q & ~gate_d;
    end
  end

  default clocking @(posedge mclk); endclocking
  default disable iff (!reset_n);

  stop_edge_a: assert property (stop_evt_q |-> !gate_q && $past(gate_q))
    else $error("stop event off the window end");
  window_bound_a: assert property (gate_q |-> tick_q < WINDOW_TICKS)
    else $error("window ran past its length");
endmodule : wpr_gate_gen

// File: wpr_pkg.sv
package wpr_pkg;
  // Widths
  localparam int CNT_W = 8;
  localparam int EXT_W = 32;
  localparam int TOT_W = CNT_W + EXT_W;
  localparam int CODE_W = 9;
  localparam int TICK_W = 16;
  localparam logic [CNT_W-1:0] CNT_MAX = 8'hFF;
  localparam logic [CODE_W-1:0] CODE_MAX = 9'h1FF;
  localparam logic [CODE_W-1:0] CODE_ZERO = 9'h000;

  // Timing
  localparam int CLK_NS = 100;
  localparam int TICK_NS = 10000;
  localparam int PRESCALE_CYC = (TICK_NS + CLK_NS - 1) / CLK_NS;
  localparam int PRE_W = 7;
  localparam int WINDOW_MS = 100;
  localparam int WINDOW_TICKS_DEF = WINDOW_MS * 1000000 / TICK_NS;
  localparam longint UPDATE_MILLIHZ = 9700;
  localparam longint PERIOD_TICKS_DEF = 64'd1000000000000 / (UPDATE_MILLIHZ * TICK_NS);
  localparam int FS_RATE_KPPS = 400;

  // Test pulse train
  localparam int TEST_FREQ_KHZ = 200;
  localparam int TEST_WIDTH_NS = 1250;
  localparam int TEST_PERIOD_CYC = 1000000 / (TEST_FREQ_KHZ * CLK_NS);
  localparam int TEST_WIDTH_CYC = (TEST_WIDTH_NS + CLK_NS - 1) / CLK_NS;
  localparam int TEST_W = 6;

  // Thresholds, 511 steps over 5 V
  localparam int THR_FS_MV = 5000;
  localparam int THR_LOWER_MV = 3000;
  localparam int THR_UPPER_MV = 4000;
  localparam logic [CODE_W-1:0] THR_LOWER_RST = CODE_W'(THR_LOWER_MV * 511 / THR_FS_MV);
  localparam logic [CODE_W-1:0] THR_UPPER_RST = CODE_W'(THR_UPPER_MV * 511 / THR_FS_MV);

  // Register map (byte addresses)
  localparam int ADDR_W = 8;
  localparam logic [ADDR_W-1:0] REG_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] REG_STATUS = 8'h04;
  localparam logic [ADDR_W-1:0] REG_MASK = 8'h08;
  localparam logic [ADDR_W-1:0] REG_RATE = 8'h0C;
  localparam logic [ADDR_W-1:0] REG_LOWER_LO = 8'h10;
  localparam logic [ADDR_W-1:0] REG_LOWER_HI = 8'h14;
  localparam logic [ADDR_W-1:0] REG_UPPER_LO = 8'h18;
  localparam logic [ADDR_W-1:0] REG_UPPER_HI = 8'h1C;
  localparam logic [ADDR_W-1:0] REG_LOWER_THR = 8'h20;
  localparam logic [ADDR_W-1:0] REG_UPPER_THR = 8'h24;

  // Control bits
  localparam int CTRL_W = 3;
  localparam int CTRL_RUN = 0;
  localparam int CTRL_INVERT = 1;
  localparam int CTRL_TEST = 2;
  localparam logic [CTRL_W-1:0] CTRL_RST = 3'h3;

  // Status / mask bits
  localparam int ST_W = 3;
  localparam int ST_LOWER_OVF = 0;
  localparam int ST_UPPER_OVF = 1;
  localparam int ST_UPDATE = 2;
  localparam logic [ST_W-1:0] ST_RST = 3'h0;

  typedef enum logic [2:0] {
    WPR_IDLE = 3'b000,
    WPR_LATCH = 3'b001,
    WPR_DIFF = 3'b010,
    WPR_SCALE = 3'b011,
    WPR_CLEAR = 3'b100
  } wpr_proc_e;
endpackage : wpr_pkg

// File: wpr_pulse_counter.sv
`timescale 1ns/1ps
module wpr_pulse_counter (
  input wire logic mclk, // System clock
  input wire logic reset_n, // Synchronous reset
  input wire logic pulse_in, // Comparator output, raw polarity
  input wire logic invert, // Restore normal polarity
  input wire logic enable, // Common gate
  input wire logic clear, // Clear count
  output logic [wpr_pkg::CNT_W-1:0] count_q, // Hardware count
  output logic ovf_q // Wrap event
);
  logic level;
  logic prev_q;
  logic edge_seen;
  logic inc;
  logic [wpr_pkg::CNT_W-1:0] count_d;
  logic ovf_d;

  assign level = pulse_in ^ invert;
  // input compared live, nothing holds it
  assign edge_seen = level & ~prev_q;
  assign inc = enable & edge_seen & ~clear;
  assign count_d = clear ? '0 : (inc ? count_q + 1'b1 : count_q);
  assign ovf_d = inc & (count_q == wpr_pkg::CNT_MAX);

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      prev_q <= 1'b0;
      count_q <= '0;
      ovf_q <= 1'b0;
    end else begin
      prev_q <= level;
      count_q <= count_d;
      ovf_q <= ovf_d;
    end
  end

  default clocking @(posedge mclk); endclocking
  default disable iff (!reset_n);

  count_step_a: assert property (inc |=> count_q == $past(count_q) + 1'b1)
    else $error("counter missed an edge");
  count_hold_a: assert property (!enable && !clear |=> count_q == $past(count_q))
    else $error("counter moved with gate closed");
  wrap_event_a: assert property (ovf_q |-> count_q == '0)
    else $error("overflow without wrap");
endmodule : wpr_pulse_counter

// File: wpr_ratemeter.sv
// Decided for this implementation: the address map and register access over APB.
`timescale 1ns/1ps
// How it works
// - Lower-level pulses and upper-level pulses are counted apart, and the window count is lower minus upper.
// - Comparator outputs arrive inverted; a control bit restores polarity and either setting counts once per pulse.
// - Comparator levels reach the counters directly with no latch holding them.
// - Each hardware counter is 8 bits and wraps are folded into a wider total.
// - A counter wrap raises an event that bumps the extension of that total.
// - Both counters share one gate so they start and stop together.
// - A 16-bit gate generator makes that gate; its compare-true span is the window.
// - Counters stop in the compare-false span, and an event at its start launches processing.
// - Each total is 40 bits: 32 from wrap increments and the low 8 read from the stopped counter.
// - Each stopped span reads both totals, subtracts, scales to 9 bits, updates the output and clears all counts.
// - The window lasts 0.1 s and the output refreshes about 9.7 times a second.
// - Pulses up to 400 kpps and down to 1.2 us wide are counted.
// - The output code is linear in rate, 511 steps, full scale at 400 kpps.
// - Threshold codes have 511 steps and default to about 3 V and 4 V of 5 V.
// - An optional test generator gives a 200 kHz train of 1.25 us pulses.
module wpr_ratemeter #(
  parameter logic [wpr_pkg::TICK_W-1:0] WINDOW_TICKS = 16'(wpr_pkg::WINDOW_TICKS_DEF), // 10 us ticks
  parameter logic [wpr_pkg::TICK_W-1:0] PERIOD_TICKS = 16'(wpr_pkg::PERIOD_TICKS_DEF) // 10 us ticks
) (
  input wire logic mclk, // System clock, 10 MHz
  input wire logic reset_n, // Synchronous reset, active low
  input wire logic lower_threshold_comparator, // Lower-level comparator, inverted
  input wire logic upper_threshold_comparator, // Upper-level comparator, inverted
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pwrite, // APB direction
  input wire logic [wpr_pkg::ADDR_W-1:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error on unmapped address
  output logic [wpr_pkg::CODE_W-1:0] lower_threshold_code, // To lower threshold converter
  output logic [wpr_pkg::CODE_W-1:0] upper_threshold_code, // To upper threshold converter
  output logic [wpr_pkg::CODE_W-1:0] rate_code, // To rate output converter
  output logic gate_broadcast_line_a, // Measurement gate
  output logic test_pulse, // Test pulse train
  output logic irq // Level interrupt
);
  localparam int FS_RAW = int'(WINDOW_TICKS) * (wpr_pkg::TICK_NS / 1000) * wpr_pkg::FS_RATE_KPPS / 1000;
  localparam logic [wpr_pkg::TICK_W-1:0] FS_COUNT = wpr_pkg::TICK_W'((FS_RAW < 1) ? 1 : FS_RAW);
  localparam int PROD_W = wpr_pkg::TICK_W + wpr_pkg::CODE_W;

  // Bus registers
  logic [31:0] prdata_q;
  logic [31:0] prdata_d;
  logic pready_q;
  logic pslverr_q;
  logic [wpr_pkg::CTRL_W-1:0] ctrl_q;
  logic [wpr_pkg::ST_W-1:0] status_q;
  logic [wpr_pkg::ST_W-1:0] status_d;
  logic [wpr_pkg::ST_W-1:0] mask_q;
  logic [wpr_pkg::CODE_W-1:0] lower_thr_q;
  logic [wpr_pkg::CODE_W-1:0] upper_thr_q;
  logic irq_q;

  // Counting and processing
  logic gate;
  logic stop_evt;
  logic [wpr_pkg::CNT_W-1:0] lower_pulse_count;
  logic [wpr_pkg::CNT_W-1:0] upper_pulse_count;
  logic lower_ovf;
  logic upper_ovf;
  logic [wpr_pkg::EXT_W-1:0] lower_ext_q;
  logic [wpr_pkg::EXT_W-1:0] upper_ext_q;
  logic [wpr_pkg::TOT_W-1:0] lower_total_count_q;
  logic [wpr_pkg::TOT_W-1:0] upper_total_count_q;
  logic [wpr_pkg::TICK_W-1:0] diff_q;
  logic [wpr_pkg::TICK_W-1:0] diff_d;
  logic [wpr_pkg::TOT_W-1:0] raw_diff;
  logic [PROD_W-1:0] scaled;
  logic [wpr_pkg::CODE_W-1:0] rate_q;
  wpr_pkg::wpr_proc_e state_q;
  wpr_pkg::wpr_proc_e state_d;
  logic clear_counts;
  logic gate_q;

  // Test generator
  logic [wpr_pkg::TEST_W-1:0] test_cnt_q;
  logic test_q;

  // Bus decode
  logic setup_ph;
  logic wr_en;
  logic hit_ctrl;
  logic hit_status;
  logic hit_mask;
  logic hit_rate;
  logic hit_llo;
  logic hit_lhi;
  logic hit_ulo;
  logic hit_uhi;
  logic hit_lthr;
  logic hit_uthr;
  logic mapped;
  logic [wpr_pkg::ST_W-1:0] events;

  function automatic logic [31:0] zext_code(input logic [wpr_pkg::CODE_W-1:0] v);
    zext_code = {{(32 - wpr_pkg::CODE_W){1'b0}}, v};
  endfunction : zext_code

  function automatic logic [31:0] total_hi(input logic [wpr_pkg::TOT_W-1:0] v);
    total_hi = {{(64 - wpr_pkg::TOT_W){1'b0}}, v[wpr_pkg::TOT_W-1:32]};
  endfunction : total_hi

  wpr_gate_gen #(
    .WINDOW_TICKS(WINDOW_TICKS),
    .PERIOD_TICKS(PERIOD_TICKS)
  ) u_measurement_gate_generator (
    .mclk(mclk),
    .reset_n(reset_n),
    .run(ctrl_q[wpr_pkg::CTRL_RUN]),
    .gate_q(gate),
    .stop_evt_q(stop_evt)
  );

  wpr_pulse_counter u_lower_pulse_counter (
    .mclk(mclk),
    .reset_n(reset_n),
    .pulse_in(lower_threshold_comparator),
    .invert(ctrl_q[wpr_pkg::CTRL_INVERT]),
    .enable(gate),
    .clear(clear_counts),
    .count_q(lower_pulse_count),
    .ovf_q(lower_ovf)
  );

  wpr_pulse_counter u_upper_pulse_counter (
    .mclk(mclk),
    .reset_n(reset_n),
    .pulse_in(upper_threshold_comparator),
    .invert(ctrl_q[wpr_pkg::CTRL_INVERT]),
    .enable(gate),
    .clear(clear_counts),
    .count_q(upper_pulse_count),
    .ovf_q(upper_ovf)
  );

  // APB decode
  assign setup_ph = psel & ~penable;
  assign wr_en = psel & penable & pready_q & pwrite;
  assign hit_ctrl = (paddr == wpr_pkg::REG_CTRL);
  assign hit_status = (paddr == wpr_pkg::REG_STATUS);
  assign hit_mask = (paddr == wpr_pkg::REG_MASK);
  assign hit_rate = (paddr == wpr_pkg::REG_RATE);
  assign hit_llo = (paddr == wpr_pkg::REG_LOWER_LO);
  assign hit_lhi = (paddr == wpr_pkg::REG_LOWER_HI);
  assign hit_ulo = (paddr == wpr_pkg::REG_UPPER_LO);
  assign hit_uhi = (paddr == wpr_pkg::REG_UPPER_HI);
  assign hit_lthr = (paddr == wpr_pkg::REG_LOWER_THR);
  assign hit_uthr = (paddr == wpr_pkg::REG_UPPER_THR);
  assign mapped = hit_ctrl | hit_status | hit_mask | hit_rate | hit_llo | hit_lhi | hit_ulo | hit_uhi |
                  hit_lthr | hit_uthr;
  assign prdata_d = hit_ctrl ? {{(32 - wpr_pkg::CTRL_W){1'b0}}, ctrl_q} :
                    hit_status ? {{(32 - wpr_pkg::ST_W){1'b0}}, status_q} :
                    hit_mask ? {{(32 - wpr_pkg::ST_W){1'b0}}, mask_q} :
                    hit_rate ? zext_code(rate_q) :
                    hit_llo ? lower_total_count_q[31:0] :
                    hit_lhi ? total_hi(lower_total_count_q) :
                    hit_ulo ? upper_total_count_q[31:0] :
                    hit_uhi ? total_hi(upper_total_count_q) :
                    hit_lthr ? zext_code(lower_thr_q) :
                    hit_uthr ? zext_code(upper_thr_q) : 32'h0000_0000;

  // Sticky events; a new event beats a write-one clear
  assign events = {state_q == wpr_pkg::WPR_CLEAR, upper_ovf, lower_ovf};
  assign status_d = (status_q & ~((wr_en & hit_status) ? pwdata[wpr_pkg::ST_W-1:0] : '0)) | events;

  // Answer in the first access cycle
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      pready_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
      pslverr_q <= 1'b0;
    end else begin
      pready_q <= setup_ph;
      prdata_q <= setup_ph ? prdata_d : prdata_q;
      pslverr_q <= setup_ph & ~mapped;
    end
  end

  // threshold defaults near 3 V and 4 V
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      ctrl_q <= wpr_pkg::CTRL_RST;
      mask_q <= wpr_pkg::ST_RST;
      lower_thr_q <= wpr_pkg::THR_LOWER_RST;
      upper_thr_q <= wpr_pkg::THR_UPPER_RST;
    end else if (wr_en) begin
      ctrl_q <= hit_ctrl ? pwdata[wpr_pkg::CTRL_W-1:0] : ctrl_q;
      mask_q <= hit_mask ? pwdata[wpr_pkg::ST_W-1:0] : mask_q;
      lower_thr_q <= hit_lthr ? pwdata[wpr_pkg::CODE_W-1:0] : lower_thr_q;
      upper_thr_q <= hit_uthr ? pwdata[wpr_pkg::CODE_W-1:0] : upper_thr_q;
    end
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      status_q <= wpr_pkg::ST_RST;
      irq_q <= 1'b0;
    end else begin
      status_q <= status_d;
      irq_q <= |(status_d & mask_q);
    end
  end

  function automatic logic [wpr_pkg::EXT_W-1:0] EXT_INC(input logic ovf);
    EXT_INC = {{(wpr_pkg::EXT_W - 1){1'b0}}, ovf};
  endfunction : EXT_INC

  always_ff @(posedge mclk) begin
    if (!reset_n || clear_counts) begin
      lower_ext_q <= '0;
      upper_ext_q <= '0;
    end else begin
      lower_ext_q <= lower_ext_q + EXT_INC(lower_ovf);
      upper_ext_q <= upper_ext_q + EXT_INC(upper_ovf);
    end
  end

  // Processing sequence in the stopped span
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      wpr_pkg::WPR_IDLE: begin
        if (stop_evt) begin
          state_d = wpr_pkg::WPR_LATCH;
        end
      end
      wpr_pkg::WPR_LATCH: state_d = wpr_pkg::WPR_DIFF;
      wpr_pkg::WPR_DIFF: state_d = wpr_pkg::WPR_SCALE;
      wpr_pkg::WPR_SCALE: state_d = wpr_pkg::WPR_CLEAR;
      wpr_pkg::WPR_CLEAR: state_d = wpr_pkg::WPR_IDLE;
      default: state_d = wpr_pkg::WPR_IDLE;
    endcase
  end

  assign clear_counts = (state_q == wpr_pkg::WPR_CLEAR);
  assign raw_diff = (lower_total_count_q > upper_total_count_q) ? lower_total_count_q - upper_total_count_q : '0;
  // full scale reached at 400 kpps
  assign diff_d = (raw_diff > {{(wpr_pkg::TOT_W - wpr_pkg::TICK_W){1'b0}}, FS_COUNT}) ? FS_COUNT :
                  raw_diff[wpr_pkg::TICK_W-1:0];
  assign scaled = PROD_W'(diff_q) * PROD_W'(wpr_pkg::CODE_MAX) / PROD_W'(FS_COUNT);

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      state_q <= wpr_pkg::WPR_IDLE;
      lower_total_count_q <= '0;
      upper_total_count_q <= '0;
      diff_q <= '0;
      rate_q <= wpr_pkg::CODE_ZERO;
      gate_q <= 1'b0;
    end else begin
      state_q <= state_d;
      gate_q <= gate;
      if (state_q == wpr_pkg::WPR_LATCH) begin
        lower_total_count_q <= {lower_ext_q, lower_pulse_count};
        upper_total_count_q <= {upper_ext_q, upper_pulse_count};
      end
      // in-window count is lower minus upper
      if (state_q == wpr_pkg::WPR_DIFF) begin
        diff_q <= diff_d;
      end
      if (state_q == wpr_pkg::WPR_SCALE) begin
        rate_q <= scaled[wpr_pkg::CODE_W-1:0];
      end
    end
  end

  // 200 kHz test train, 1.25 us wide
  always_ff @(posedge mclk) begin
    if (!reset_n || !ctrl_q[wpr_pkg::CTRL_TEST]) begin
      test_cnt_q <= '0;
      test_q <= 1'b0;
    end else begin
      test_cnt_q <= (test_cnt_q == wpr_pkg::TEST_W'(wpr_pkg::TEST_PERIOD_CYC - 1)) ? '0 : test_cnt_q + 1'b1;
      test_q <= (test_cnt_q < wpr_pkg::TEST_W'(wpr_pkg::TEST_WIDTH_CYC - 1)) ||
                (test_cnt_q == wpr_pkg::TEST_W'(wpr_pkg::TEST_PERIOD_CYC - 1));
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign lower_threshold_code = lower_thr_q;
  assign upper_threshold_code = upper_thr_q;
  assign rate_code = rate_q;
  assign gate_broadcast_line_a = gate_q;
  assign test_pulse = test_q;
  assign irq = irq_q;

  default clocking @(posedge mclk); endclocking
  default disable iff (!reset_n);

  ext_step_a: assert property (lower_ovf && !clear_counts |=> lower_ext_q == $past(lower_ext_q) + 1'b1)
    else $error("wrap did not extend lower total");
  stop_only_a: assert property (state_q != wpr_pkg::WPR_IDLE |-> !gate)
    else $error("processing while window open");
  latch_total_a: assert property (state_q == wpr_pkg::WPR_LATCH |=>
      lower_total_count_q == {$past(lower_ext_q), $past(lower_pulse_count)})
    else $error("total not built from extension and counter");
  diff_clamp_a: assert property (state_q == wpr_pkg::WPR_DIFF && upper_total_count_q >= lower_total_count_q
      |=> diff_q == '0)
    else $error("negative difference not clamped");
  clear_all_a: assert property (clear_counts |=> lower_pulse_count == '0 && upper_pulse_count == '0 &&
      lower_ext_q == '0 && upper_ext_q == '0)
    else $error("counts not cleared");
  proc_seq_a: assert property (stop_evt && state_q == wpr_pkg::WPR_IDLE |=> ##3 clear_counts)
    else $error("processing sequence out of step");
  full_scale_a: assert property (state_q == wpr_pkg::WPR_SCALE && diff_q == FS_COUNT
      |=> rate_q == wpr_pkg::CODE_MAX)
    else $error("full scale code wrong");
  sticky_set_a: assert property (lower_ovf |=> status_q[wpr_pkg::ST_LOWER_OVF])
    else $error("overflow event lost");
  apb_ready_a: assert property (setup_ph |=> pready_q ##1 !pready_q)
    else $error("ready not one cycle");
endmodule : wpr_ratemeter
